// ---- dv/tiop_pins_model.sv ----
// Pin-side partner: resolves pin levels, drives input strobes, captures strobed output
`timescale 1ns/1ns
module tiop_pins_model import tiop_pkg::*; (
    // Clock
    input wire logic clk,
    // Device pins
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [NP-1:0] stb_out,
    output logic [31:0] pin_in,
    output logic [NP-1:0] stb_in,
    // Bench control
    input wire logic [31:0] ext_val,
    input wire logic [NP-1:0] ext_stb,
    output logic [31:0] cap_q,
    output logic [7:0] n_stb_q
);
    // A floating pin shows what the outside drives, never the last device value
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            pin_in[i] = pin_oe_n[i] ? ext_val[i] : pin_out[i];
        end
    end
    // Outside hardware qualifies its data with the input strobe
    assign stb_in = ext_stb;
    initial cap_q = 32'h0000_0000;
    initial n_stb_q = 8'h00;
    // Capture on any output strobe, as a receiving device would
    always @(posedge clk) begin
        if (|stb_out) begin
            cap_q <= pin_in;
            n_stb_q <= n_stb_q + 8'h01;
        end
    end
endmodule

// ---- dv/tiop_top_tb.sv ----
// Self-checking bench for the timed I/O port block
`timescale 1ns/1ns
module tiop_top_tb import tiop_pkg::*; ;
    localparam logic [31:0] LMASK = 32'hFF00_0000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic [31:0] pin_in;
    logic [31:0] pin_out;
    logic [31:0] pin_oe_n;
    logic [NP-1:0] stb_in;
    logic [NP-1:0] stb_out;
    logic [31:0] ltxd = 32'h0000_0000;
    logic [31:0] ltx_oe_n = 32'hFFFF_FFFF;
    logic [31:0] lrxd;
    logic irq;
    logic [31:0] ext_val = 32'h0000_0000;
    logic [NP-1:0] ext_stb = 5'h00;
    logic [31:0] cap;
    logic [7:0] n_stb;
    int n_errors = 0;
    int n_tests = 0;

    always #50 clk = ~clk;

    tiop_top #(.LINK_MASK(LMASK)) i_dut (
        .SYS_CLK(clk), .RST(rst), .ADDR(addr), .WR_DATA(wdata), .WR_EN(wr_en),
        .RD_EN(rd_en), .RD_DATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
        .PIN_OE_N(pin_oe_n), .STROBE_IN(stb_in), .STROBE_OUT(stb_out),
        .LINK_TXD(ltxd), .LINK_TX_OE_N(ltx_oe_n), .LINK_RXD(lrxd), .IRQ(irq)
    );
    tiop_pins_model i_pins (
        .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .stb_out(stb_out),
        .pin_in(pin_in), .stb_in(stb_in), .ext_val(ext_val), .ext_stb(ext_stb),
        .cap_q(cap), .n_stb_q(n_stb)
    );
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Tasks start just after an edge, so a strobe is never set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rd2(input logic [7:0] a, output logic [31:0] d1, output logic [31:0] d2);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        #1;
        d1 = rdata;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d2 = rdata;
    endtask
    task automatic wait_stb(input int p);
        for (int i = 0; i < 20; i++) begin
            cyc(1);
            if (stb_out[p] === 1'b1) break;
        end
        chk({31'h0, stb_out[p]}, 32'h0000_0001, "output strobe");
    endtask
    // Port 1 is held off by the first setting and takes a word with the second
    task automatic cnd(input logic [31:0] ctl, input logic [31:0] v0, input logic s0,
                       input logic [31:0] v1, input logic s1);
        logic [31:0] d;
        wr(8'h20, 32'h0000_0000);
        rd(8'h24, d);
        ext_val <= v0;
        ext_stb <= {3'h0, s0, 1'b0};
        wr(8'h20, ctl);
        cyc(6);
        rd(8'h38, d);
        chk(d & 32'h0000_0001, 32'h0000_0000, "held off");
        ext_val <= v1;
        ext_stb <= {3'h0, s1, 1'b0};
        cyc(6);
        rd(8'h38, d);
        chk(d & 32'h0000_0001, 32'h0000_0001, "taken");
        rd(8'h24, d);
        chk(d & 32'h0000_000F, v1 & 32'h0000_000F, "sampled word");
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        logic [31:0] d;
        logic [31:0] c;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(pin_oe_n, 32'hFFFF_FFFF, "idle enables");
        chk({31'h0, irq}, 32'h0000_0000, "idle irq");
        for (int p = 0; p < NP; p++) begin
            rd(8'(p * 32), d);
            chk(d, 32'h0000_0000, "ctrl after reset");
        end
        wr(CB_BASE, 32'h0000_0003);
        rd(CB_BASE, d);
        chk(d, 32'h0000_0000, "block zero fixed");
        rd(8'hF0, d);
        chk(d, 32'h0000_0000, "unmapped read");
        $display("test reset done");
        // Parallel 32-bit output, strobe and interrupt
        wr(8'h80, 32'h0000_0023);
        wr(8'h84, 32'hA5C3_0F96);
        wait_stb(4);
        chk(pin_out, 32'hA5C3_0F96, "parallel out");
        chk(pin_oe_n, 32'h0000_0000, "all driven");
        cyc(2);
        chk(cap, 32'hA5C3_0F96, "captured");
        chk({31'h0, irq}, 32'h0000_0000, "masked irq");
        rd(IRQ_STAT, d);
        chk(d, 32'h0000_0010, "status set");
        wr(IRQ_MASK, 32'h0000_0010);
        cyc(2);
        chk({31'h0, irq}, 32'h0000_0001, "irq raised");
        wr(IRQ_STAT, 32'h0000_0010);
        cyc(2);
        chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
        rd(IRQ_STAT, d);
        chk(d, 32'h0000_0000, "status cleared");
        $display("test output done");
        // Open-drain 8-bit port over the 32-bit port
        wr(8'h40, 32'h0000_0027);
        wr(8'h44, 32'h0000_005A);
        wait_stb(2);
        chk(pin_out, 32'hA5C3_0F00, "open drain out");
        chk(pin_oe_n, 32'h0000_005A, "open drain oe");
        $display("test open drain done");
        // Serial 16-bit output, low chunk first
        wr(8'h40, 32'h0000_0000);
        wr(8'h60, 32'h0000_002B);
        wr(8'h64, 32'hBEEF_1234);
        wait_stb(3);
        chk(pin_out, 32'hA5C3_1234, "first chunk");
        wait_stb(3);
        chk(pin_out, 32'hA5C3_BEEF, "second chunk");
        $display("test serial done");
        // Link takes its pins, then hands them back
        ltxd <= 32'h3C00_0000;
        ltx_oe_n <= 32'h0000_0000;
        wr(LINK_CTRL, 32'h0000_0001);
        cyc(4);
        chk(pin_out & LMASK, 32'h3C00_0000, "link out");
        chk(pin_oe_n & LMASK, 32'h0000_0000, "link oe");
        chk(pin_out & ~LMASK, 32'h00C3_BEEF, "ports kept");
        chk(lrxd, 32'h3C00_0000, "link rx");
        wr(LINK_CTRL, 32'h0000_0000);
        cyc(4);
        chk(lrxd, 32'h0000_0000, "link rx off");
        chk(pin_out & LMASK, 32'hA500_0000, "port back");
        for (int p = 0; p < NP; p++) begin
            wr(8'(p * 32), 32'h0000_0000);
        end
        $display("test link done");
        // 16-bit input, counter, timed transfer and timestamp
        ext_val <= 32'h0000_1234;
        cyc(3);
        wr(8'h60, 32'h0000_0001);
        cyc(6);
        rd(8'h78, d);
        chk(d & 32'h0000_0001, 32'h0000_0001, "input full");
        rd(8'h64, d);
        chk(d & 32'h0000_FFFF, 32'h0000_1234, "input word");
        rd2(8'h68, c, d);
        chk(d - c, 32'h0000_0001, "counter step");
        ext_val <= 32'h0000_5678;
        cyc(4);
        rd(8'h68, c);
        wr(8'h6C, {16'h0, c[15:0] + 16'h0028});
        rd(8'h64, d);
        rd(8'h78, d);
        chk(d & 32'h0000_0003, 32'h0000_0002, "held to time");
        cyc(50);
        rd(8'h78, d);
        chk(d & 32'h0000_0003, 32'h0000_0001, "timed done");
        rd(8'h70, d);
        chk(d, {16'h0, c[15:0] + 16'h0028}, "timestamp");
        rd(8'h64, d);
        chk(d & 32'h0000_FFFF, 32'h0000_5678, "timed word");
        wr(8'h60, 32'h0000_0000);
        $display("test timed input done");
        // Conditions and input strobe on the 4-bit port
        wr(8'h34, 32'h0000_0005);
        cnd(32'h0000_0041, 32'h0000_0003, 1'b0, 32'h0000_0005, 1'b0);
        cnd(32'h0000_0081, 32'h0000_0005, 1'b0, 32'h0000_0006, 1'b0);
        cnd(32'h0000_0011, 32'h0000_0009, 1'b0, 32'h0000_0009, 1'b1);
        wr(8'h20, 32'h0000_0000);
        $display("test condition done");
        // Clock block 1 from pin 0, divided by two
        ext_val <= 32'h0000_0000;
        ext_stb <= 5'h00;
        wr(8'hA4, 32'h0000_0003);
        rd(8'hA4, d);
        chk(d, 32'h0000_0003, "block setting");
        wr(8'h80, 32'h0000_0101);
        rd(8'h88, c);
        repeat (8) begin
            ext_val <= 32'h0000_0001;
            cyc(3);
            ext_val <= 32'h0000_0000;
            cyc(3);
        end
        rd(8'h88, d);
        chk(d - c, 32'h0000_0004, "pin clock ticks");
        $display("test clock block done");
        print_verdict();
    end
endmodule

// ---- include/tiop_pkg.sv ----
// Shared constants and types of the timed I/O port block
package tiop_pkg;
    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NP = 5;
    localparam int NCB = 6;
    localparam int CFG_W = 11;
    localparam logic [5:0] PORT_W [NP] = '{6'h01, 6'h04, 6'h08, 6'h10, 6'h20};
    // Last sample index of a serialised 32-bit word, per port width
    localparam logic [4:0] PORT_LIM [NP] = '{5'h1F, 5'h07, 5'h03, 5'h01, 5'h00};
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] PORT_END = 8'hA0;
    localparam logic [4:0] R_CTRL = 5'h00;
    localparam logic [4:0] R_DATA = 5'h04;
    localparam logic [4:0] R_COUNT = 5'h08;
    localparam logic [4:0] R_TIME = 5'h0C;
    localparam logic [4:0] R_STAMP = 5'h10;
    localparam logic [4:0] R_COND = 5'h14;
    localparam logic [4:0] R_STAT = 5'h18;
    localparam logic [7:0] CB_BASE = 8'hA0;
    localparam logic [7:0] CB_END = 8'hB8;
    localparam logic [7:0] IRQ_STAT = 8'hC0;
    localparam logic [7:0] IRQ_MASK = 8'hC4;
    localparam logic [7:0] LINK_CTRL = 8'hC8;
    // Condition modes
    localparam logic [1:0] COND_NONE = 2'h0;
    localparam logic [1:0] COND_EQ = 2'h1;
    localparam logic [1:0] COND_NE = 2'h2;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] cb;
        logic [1:0] cond;
        logic sout;
        logic sin;
        logic ser;
        logic od;
        logic out;
        logic en;
    } tiop_cfg_t;
    typedef struct packed {
        tiop_cfg_t cfg;
        logic [31:0] xfer;
        logic [31:0] sr;
        logic [4:0] cnt;
        logic full;
        logic timed;
        logic [15:0] ctr;
        logic [15:0] tgt;
        logic [15:0] stamp;
        logic [31:0] condv;
        logic [31:0] pout;
    } tiop_port_t;
    typedef struct packed {
        logic src;
        logic [7:0] div;
        logic [7:0] divc;
        logic prev;
    } tiop_cb_t;
    typedef struct packed {
        tiop_port_t [NP-1:0] port;
        tiop_cb_t [NCB-1:0] cb;
        logic [31:0] s1;
        logic [31:0] s2;
        logic [NP-1:0] st1;
        logic [NP-1:0] st2;
        logic [NP-1:0] ists;
        logic [NP-1:0] imsk;
        logic link_en;
        logic [31:0] rdata;
        logic [31:0] pin_o;
        logic [31:0] pin_oe_n;
        logic [31:0] lrx;
        logic [NP-1:0] sout;
        logic irq;
    } tiop_state_t;
endpackage

// ---- src/tiop_top.sv ----
// Timed I/O ports with clock blocks, pin sharing and register port
`timescale 1ns/1ns
// How it works
// - Ports of 1, 4, 8, 16, 32 bits
// - Each port wholly input or wholly output
// - Drive pins, or sample with optional condition
// - Every register access completes in one cycle
// - Per-port open drain: zero pulls, one floats
// - Shift register plus transfer register per port
// - Sixteen-bit counter times pin transfers
// - Counter readable; transfers can wait for time
// - Counter captured as timestamp on transfer
// - Enabled link owns its shared pins
// - Narrower enabled port wins shared pins
// - Clock blocks set each port's rate
// - Six blocks; block zero is reference
// - Block may clock from one-bit port pin
// - Pin-sourced block clock optionally divided
// - Input strobe qualifies sampled data
// - Output strobe accompanies driven data
// - After reset all ports use block zero
module tiop_top import tiop_pkg::*; #(
    parameter logic [31:0] LINK_MASK = 32'hFF00_0000
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // Register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WR_DATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [31:0] RD_DATA,
    // Pins
    input wire logic [31:0] PIN_IN,
    output logic [31:0] PIN_OUT,
    output logic [31:0] PIN_OE_N,
    // Strobes
    input wire logic [NP-1:0] STROBE_IN,
    output logic [NP-1:0] STROBE_OUT,
    // Link side
    input wire logic [31:0] LINK_TXD,
    input wire logic [31:0] LINK_TX_OE_N,
    output logic [31:0] LINK_RXD,
    // Interrupt
    output logic IRQ
);
    tiop_state_t q;
    tiop_state_t d;
    logic [NCB-1:0] tick;
    logic [NP-1:0] ev;
    logic [31:0] own [NP];

    function automatic logic [31:0] wmask(input logic [5:0] w);
        wmask = 32'hFFFF_FFFF >> (6'h20 - w);
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] taken;
        logic [31:0] lm;
        logic [31:0] drv;
        logic [31:0] samp;
        logic [31:0] msk;
        logic [31:0] nsr;
        logic t;
        logic go;
        logic last;
        logic [2:0] ci;
        taken = '0;
        lm = '0;
        drv = '0;
        samp = '0;
        msk = '0;
        nsr = '0;
        t = 1'b0;
        go = 1'b0;
        last = 1'b0;
        ci = '0;
        d = q;
        ev = '0;
        // Pins pass two flops before use
        d.s1 = PIN_IN;
        d.s2 = q.s1;
        d.st1 = STROBE_IN;
        d.st2 = q.st1;
        d.sout = '0;

        // Block zero ticks on every reference edge
        tick = '0;
        tick[0] = 1'b1;
        for (int k = 1; k < NCB; k++) begin
            d.cb[k].prev = q.s2[0];
            if (!q.cb[k].src) begin
                tick[k] = 1'b1;
            end else if (q.s2[0] && !q.cb[k].prev) begin
                if (q.cb[k].divc == q.cb[k].div) begin
                    tick[k] = 1'b1;
                    d.cb[k].divc = '0;
                end else begin
                    d.cb[k].divc = 8'(q.cb[k].divc + 8'h01);
                end
            end
        end

        // Link first, then ports from narrowest up
        lm = q.link_en ? LINK_MASK : '0;
        taken = lm;
        for (int p = 0; p < NP; p++) begin
            own[p] = q.port[p].cfg.en ? (wmask(PORT_W[p]) & ~taken) : '0;
            taken = taken | own[p];
        end

        // Port transfers on the chosen block's tick
        for (int p = 0; p < NP; p++) begin
            ci = q.port[p].cfg.cb;
            t = (int'(ci) < NCB) ? tick[ci] : 1'b0;
            msk = wmask(PORT_W[p]);
            samp = q.s2 & msk;
            last = !q.port[p].cfg.ser || (q.port[p].cnt == PORT_LIM[p]);
            go = t && q.port[p].cfg.en;
            go = go && (!q.port[p].timed || q.port[p].ctr == q.port[p].tgt);
            if (t) begin
                d.port[p].ctr = 16'(q.port[p].ctr + 16'h0001);
            end
            if (!q.port[p].cfg.out) begin
                go = go && !q.port[p].full;
                go = go && (!q.port[p].cfg.sin || q.st2[p]);
                unique case (q.port[p].cfg.cond)
                    COND_EQ: go = go && (samp == (q.port[p].condv & msk));
                    COND_NE: go = go && (samp != (q.port[p].condv & msk));
                    default: go = go;
                endcase
                if (go) begin
                    nsr = q.port[p].cfg.ser ?
                        ((q.port[p].sr >> PORT_W[p]) | (samp << (6'h20 - PORT_W[p]))) : samp;
                    d.port[p].sr = nsr;
                    if (last) begin
                        d.port[p].xfer = nsr;
                        d.port[p].full = 1'b1;
                        d.port[p].cnt = '0;
                        d.port[p].stamp = q.port[p].ctr;
                        d.port[p].timed = 1'b0;
                        ev[p] = 1'b1;
                    end else begin
                        d.port[p].cnt = 5'(q.port[p].cnt + 5'h01);
                    end
                end
            end else if (go && q.port[p].full) begin
                d.port[p].pout = (q.port[p].xfer >> (q.port[p].cnt * PORT_W[p])) & msk;
                d.sout[p] = q.port[p].cfg.sout;
                if (last) begin
                    d.port[p].full = 1'b0;
                    d.port[p].cnt = '0;
                    d.port[p].stamp = q.port[p].ctr;
                    d.port[p].timed = 1'b0;
                    ev[p] = 1'b1;
                end else begin
                    d.port[p].cnt = 5'(q.port[p].cnt + 5'h01);
                end
            end
        end

        // Pin drive follows the new sample, so data and output strobe leave together
        d.pin_o = '0;
        d.pin_oe_n = '1;
        for (int p = 0; p < NP; p++) begin
            if (q.port[p].cfg.out) begin
                drv = q.port[p].cfg.od ? (own[p] & ~d.port[p].pout) : own[p];
                d.pin_o = d.pin_o | (own[p] & d.port[p].pout & {32{~q.port[p].cfg.od}});
                d.pin_oe_n = d.pin_oe_n & ~drv;
            end
        end
        d.pin_o = (d.pin_o & ~lm) | (LINK_TXD & lm);
        d.pin_oe_n = (d.pin_oe_n & ~lm) | (LINK_TX_OE_N & lm);
        d.lrx = q.s2 & lm;

        // Register writes; a new word wins over a drain in the same cycle
        if (WR_EN) begin
            for (int p = 0; p < NP; p++) begin
                if (ADDR < PORT_END && int'(ADDR[7:5]) == p) begin
                    unique case (ADDR[4:0])
                        R_CTRL: d.port[p].cfg = tiop_cfg_t'(WR_DATA[CFG_W-1:0]);
                        R_DATA: begin
                            if (q.port[p].cfg.out) begin
                                d.port[p].xfer = WR_DATA;
                                d.port[p].full = 1'b1;
                                d.port[p].cnt = '0;
                            end
                        end
                        R_TIME: begin
                            d.port[p].tgt = WR_DATA[15:0];
                            d.port[p].timed = 1'b1;
                        end
                        R_COND: d.port[p].condv = WR_DATA;
                        default: d.port[p].condv = d.port[p].condv;
                    endcase
                end
            end
            for (int k = 1; k < NCB; k++) begin
                if (ADDR == 8'(CB_BASE + 8'(k * 4))) begin
                    d.cb[k].src = WR_DATA[0];
                    d.cb[k].div = WR_DATA[8:1];
                    d.cb[k].divc = '0;
                end
            end
            if (ADDR == IRQ_MASK) begin
                d.imsk = WR_DATA[NP-1:0];
            end
            if (ADDR == LINK_CTRL) begin
                d.link_en = WR_DATA[0];
            end
        end
        // Sticky events: a new event wins over the write-one clear
        d.ists = q.ists;
        if (WR_EN && ADDR == IRQ_STAT) begin
            d.ists = q.ists & ~WR_DATA[NP-1:0];
        end
        d.ists = d.ists | ev;

        // Register reads, answered in the next cycle
        d.rdata = '0;
        if (RD_EN) begin
            for (int p = 0; p < NP; p++) begin
                if (ADDR < PORT_END && int'(ADDR[7:5]) == p) begin
                    unique case (ADDR[4:0])
                        R_CTRL: d.rdata = {21'h00_0000, q.port[p].cfg};
                        R_DATA: begin
                            d.rdata = q.port[p].xfer;
                            if (!q.port[p].cfg.out && q.port[p].full) begin
                                d.port[p].full = 1'b0;
                            end
                        end
                        R_COUNT: d.rdata = {16'h0000, q.port[p].ctr};
                        R_TIME: d.rdata = {16'h0000, q.port[p].tgt};
                        R_STAMP: d.rdata = {16'h0000, q.port[p].stamp};
                        R_COND: d.rdata = q.port[p].condv;
                        R_STAT: d.rdata = {30'h0000_0000, q.port[p].timed, q.port[p].full};
                        default: d.rdata = '0;
                    endcase
                end
            end
            for (int k = 0; k < NCB; k++) begin
                if (ADDR == 8'(CB_BASE + 8'(k * 4))) begin
                    d.rdata = {23'h00_0000, q.cb[k].div, q.cb[k].src};
                end
            end
            if (ADDR == IRQ_STAT) begin
                d.rdata = {27'h000_0000, q.ists};
            end
            if (ADDR == IRQ_MASK) begin
                d.rdata = {27'h000_0000, q.imsk};
            end
            if (ADDR == LINK_CTRL) begin
                d.rdata = {31'h0000_0000, q.link_en};
            end
        end
        d.irq = |(d.ists & d.imsk);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            q <= '0;
            q.pin_oe_n <= '1;
        end else begin
            q <= d;
        end
    end

    assign RD_DATA = q.rdata;
    assign PIN_OUT = q.pin_o;
    assign PIN_OE_N = q.pin_oe_n;
    assign STROBE_OUT = q.sout;
    assign LINK_RXD = q.lrx;
    assign IRQ = q.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_reset_cb;
        @(posedge SYS_CLK) $past(RST) && !RST |-> q.port[4].cfg.cb == 3'h0 && PIN_OE_N == '1;
    endproperty
    a_reset_cb: assert property (p_reset_cb) else $error("port not on block zero");

    property p_count_read;
        @(posedge SYS_CLK) disable iff (RST)
        RD_EN && ADDR == {3'h0, R_COUNT} |=> RD_DATA == {16'h0000, $past(q.port[0].ctr)};
    endproperty
    a_count_read: assert property (p_count_read) else $error("counter read wrong");

    property p_count_step;
        @(posedge SYS_CLK) disable iff (RST)
        q.port[1].cfg.cb == 3'h0 |=> q.port[1].ctr == 16'($past(q.port[1].ctr) + 16'h0001);
    endproperty
    a_count_step: assert property (p_count_step) else $error("counter did not step");

    property p_stamp;
        @(posedge SYS_CLK) disable iff (RST) ev[2] |=> q.port[2].stamp == $past(q.port[2].ctr);
    endproperty
    a_stamp: assert property (p_stamp) else $error("timestamp not captured");

    property p_timed_hold;
        @(posedge SYS_CLK) disable iff (RST)
        q.port[3].timed && q.port[3].ctr != q.port[3].tgt |-> !ev[3];
    endproperty
    a_timed_hold: assert property (p_timed_hold) else $error("transfer before time");

    property p_open_drain;
        @(posedge SYS_CLK) disable iff (RST)
        q.port[0].cfg.out && q.port[0].cfg.od && own[0][0] && d.port[0].pout[0] |=> PIN_OE_N[0];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

    property p_link_owns;
        @(posedge SYS_CLK) disable iff (RST)
        q.link_en |=> (PIN_OE_N & LINK_MASK) == ($past(LINK_TX_OE_N) & LINK_MASK)
            && (PIN_OUT & LINK_MASK) == ($past(LINK_TXD) & LINK_MASK);
    endproperty
    a_link_owns: assert property (p_link_owns) else $error("link lost its pins");

    property p_narrow_wins;
        @(posedge SYS_CLK) disable iff (RST)
        q.port[0].cfg.en && !q.link_en |-> own[1][0] == 1'b0 && own[4][0] == 1'b0;
    endproperty
    a_narrow_wins: assert property (p_narrow_wins) else $error("wide port took pin");

    property p_input_float;
        @(posedge SYS_CLK) disable iff (RST)
        !q.link_en && q.port[4].cfg.en && !q.port[4].cfg.out && q.port[0].cfg.out == 1'b0
            && q.port[1].cfg.out == 1'b0 && q.port[2].cfg.out == 1'b0
            && q.port[3].cfg.out == 1'b0 |=> PIN_OE_N == '1;
    endproperty
    a_input_float: assert property (p_input_float) else $error("input port drove pins");

    property p_out_strobe;
        @(posedge SYS_CLK) disable iff (RST)
        ev[1] && q.port[1].cfg.out && q.port[1].cfg.sout |=> STROBE_OUT[1];
    endproperty
    a_out_strobe: assert property (p_out_strobe) else $error("output strobe missing");

    property p_in_strobe;
        @(posedge SYS_CLK) disable iff (RST)
        !q.port[2].cfg.out && q.port[2].cfg.sin && !q.st2[2] |-> !ev[2];
    endproperty
    a_in_strobe: assert property (p_in_strobe) else $error("sample without strobe");
endmodule
